// ---- inc/cee_pkg.sv ----
`default_nettype none
// Shared constants of the exception entry unit.
package cee_pkg;
	// APB register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] SAVED_OFS = 8'h08;
	localparam logic [7:0] LINK_OFS = 8'h0c;
	localparam logic [7:0] RETURN_OFS = 8'h10;
	localparam logic [7:0] CAUSE_OFS = 8'h14;
	// Control register field.
	localparam int CTRL_HIVEC_BIT = 0;
	// Status word control byte layout.
	localparam int IMASK_BIT = 7;
	localparam int FMASK_BIT = 6;
	localparam int TSTATE_BIT = 5;
	localparam int MODE_MSB = 4;
	// Mode encodings.
	localparam logic [4:0] MODE_USER = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;
	localparam logic [4:0] MODE_SYS = 5'h1f;
	// Banked register slots; NO_BANK marks user and system mode.
	localparam logic [2:0] BANK_FIQ = 3'h0;
	localparam logic [2:0] BANK_SVC = 3'h1;
	localparam logic [2:0] BANK_ABT = 3'h2;
	localparam logic [2:0] BANK_IRQ = 3'h3;
	localparam logic [2:0] BANK_UND = 3'h4;
	localparam logic [2:0] NO_BANK = 3'h7;
	localparam int BANK_COUNT = 5;
	// Status reset: supervisor, both masks set, full-width state.
	localparam logic [7:0] STATUS_RESET = 8'hd3;
	// Vector bases and offsets.
	localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
	localparam logic [31:0] VEC_BASE_HIGH = 32'hffff_0000;
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
	localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
	localparam logic [31:0] VEC_FETCH_ABT = 32'h0000_000c;
	localparam logic [31:0] VEC_DATA_ABT = 32'h0000_0010;
	localparam logic [31:0] VEC_RSVD = 32'h0000_0014;
	localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
	localparam logic [31:0] VEC_FIQ = 32'h0000_001c;
	// Return address offsets.
	localparam logic [31:0] LINK_PLUS2 = 32'h0000_0002;
	localparam logic [31:0] LINK_PLUS4 = 32'h0000_0004;
	localparam logic [31:0] LINK_PLUS8 = 32'h0000_0008;
	// Transfer kinds of the instruction at the head.
	localparam logic [1:0] XFER_SINGLE = 2'h0;
	localparam logic [1:0] XFER_SWAP = 2'h1;
	localparam logic [1:0] XFER_BLOCK = 2'h2;
	typedef enum logic [2:0] {
		CAUSE_NONE, CAUSE_RESET, CAUSE_UNDEF, CAUSE_TRAP, CAUSE_FETCH_ABT, CAUSE_DATA_ABT, CAUSE_IRQ, CAUSE_FIQ
	} cee_cause_type;
	typedef enum logic [0:0] {SEQ_RUN, SEQ_CHAIN} cee_seq_type;
endpackage
`default_nettype wire

// ---- rtl/cee_exception_unit.sv ----
// Functional notes
// - Full-width entry saves PC plus four or eight.
// - Entry copies status word into target saved word.
// - Entry forces mode and loads the vector on the same edge.
// - Compressed state switches to full-width at vector.
// - Compressed link offsets: two, four or eight.
// - Return restores status including state bit.
// - Both interrupt requests pass a synchroniser.
// - Fast interrupt sampled at instruction end unless masked.
// - Normal interrupt on low unless masked.
// - Mask bits change only in privileged mode.
// - Abort from protection unit or bus error.
// - Prefetch abort tagged, taken only at head.
// - Aborted single transfer keeps base write-back.
// - Aborted swap leaves state untouched.
// - Aborted block transfer suppresses later register loads.
// - Undecodable instruction takes the undefined trap.
// - Vector base low or high, fixed offsets.
// - Fixed priority among simultaneous exceptions.
// - Undefined and software trap never together.
// - Data abort then fast interrupt immediately.
// - Five-bit mode encodings, others illegal.
// - Two mask bits disable the interrupt classes.
`default_nettype none
module cee_exception_unit (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic fast_irq_req_n,
	input wire logic normal_irq_req_n,
	input wire logic bus_error_in,
	input wire logic protFault,
	input wire logic fetchValid,
	input wire logic pipeFlush,
	input wire logic dataAccess,
	input wire logic instrEnd,
	input wire logic [31:0] instrPc,
	input wire logic decodeUndef,
	input wire logic decodeTrap,
	input wire logic [1:0] xferKind,
	input wire logic loadReq,
	input wire logic wbReq,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pcLoad,
	output logic [31:0] pcTarget,
	output logic [7:0] current_status_word,
	output logic regLoadCommit,
	output logic baseWbCommit
);
	localparam int BANK_COUNT = cee_pkg::BANK_COUNT;
	logic fiqMeta, fiqSync, irqMeta, irqSync;
	logic hiVec, headAbortTag, dataAbtPending, abortInInstr;
	logic [7:0] saved_status_word [BANK_COUNT];
	logic [31:0] banked_link_reg [BANK_COUNT];
	cee_pkg::cee_seq_type seq;
	cee_pkg::cee_cause_type lastCause, entryCause;
	logic abortNow, fiqTake, irqTake, dataAbtTake, fetchAbtTake, undefTake, trapTake;
	logic entryFire, retFire, apbWrite, apbSetup, privileged;
	logic [31:0] entryPc, entryLink, entryVec;
	logic [4:0] entryMode;
	logic [2:0] entryBank, curBank;

	// Maps a mode to its banked slot; user and system have none.
	function automatic logic [2:0] bankOf(input logic [4:0] mode);
		case (mode)
			cee_pkg::MODE_FIQ: bankOf = cee_pkg::BANK_FIQ;
			cee_pkg::MODE_SVC: bankOf = cee_pkg::BANK_SVC;
			cee_pkg::MODE_ABT: bankOf = cee_pkg::BANK_ABT;
			cee_pkg::MODE_IRQ: bankOf = cee_pkg::BANK_IRQ;
			cee_pkg::MODE_UND: bankOf = cee_pkg::BANK_UND;
			default: bankOf = cee_pkg::NO_BANK;
		endcase
	endfunction

	// True for the seven legal mode encodings only.
	function automatic logic modeLegal(input logic [4:0] mode);
		modeLegal = (mode == cee_pkg::MODE_USER) || (mode == cee_pkg::MODE_SYS) ||
			(bankOf(mode) != cee_pkg::NO_BANK);
	endfunction

	// Mode entered by each exception.
	function automatic logic [4:0] modeOf(input cee_pkg::cee_cause_type cause);
		case (cause)
			cee_pkg::CAUSE_UNDEF: modeOf = cee_pkg::MODE_UND;
			cee_pkg::CAUSE_FETCH_ABT, cee_pkg::CAUSE_DATA_ABT: modeOf = cee_pkg::MODE_ABT;
			cee_pkg::CAUSE_IRQ: modeOf = cee_pkg::MODE_IRQ;
			cee_pkg::CAUSE_FIQ: modeOf = cee_pkg::MODE_FIQ;
			default: modeOf = cee_pkg::MODE_SVC;
		endcase
	endfunction

	// Vector offset of each exception, added to the selected base.
	function automatic logic [31:0] vecOf(input cee_pkg::cee_cause_type cause);
		case (cause)
			cee_pkg::CAUSE_RESET: vecOf = cee_pkg::VEC_RESET;
			cee_pkg::CAUSE_UNDEF: vecOf = cee_pkg::VEC_UNDEF;
			cee_pkg::CAUSE_TRAP: vecOf = cee_pkg::VEC_TRAP;
			cee_pkg::CAUSE_FETCH_ABT: vecOf = cee_pkg::VEC_FETCH_ABT;
			cee_pkg::CAUSE_DATA_ABT: vecOf = cee_pkg::VEC_DATA_ABT;
			cee_pkg::CAUSE_IRQ: vecOf = cee_pkg::VEC_IRQ;
			cee_pkg::CAUSE_FIQ: vecOf = cee_pkg::VEC_FIQ;
			default: vecOf = cee_pkg::VEC_RSVD;
		endcase
	endfunction

	// Offset added to the current PC to form the saved return address.
	function automatic logic [31:0] linkOfs(input cee_pkg::cee_cause_type cause, input logic compressed);
		case (cause)
			cee_pkg::CAUSE_DATA_ABT: linkOfs = cee_pkg::LINK_PLUS8;
			cee_pkg::CAUSE_TRAP, cee_pkg::CAUSE_UNDEF:
				linkOfs = compressed ? cee_pkg::LINK_PLUS2 : cee_pkg::LINK_PLUS4;
			default: linkOfs = cee_pkg::LINK_PLUS4;
		endcase
	endfunction

	// Two-stage synchronisers on the asynchronous request pins.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fiqMeta <= 1'b1;
			fiqSync <= 1'b1;
			irqMeta <= 1'b1;
			irqSync <= 1'b1;
		end else begin
			fiqMeta <= fast_irq_req_n;
			fiqSync <= fiqMeta;
			irqMeta <= normal_irq_req_n;
			irqSync <= irqMeta;
		end
	end

	// Candidate exceptions, all judged at the end of an instruction.
	assign abortNow = dataAccess && (protFault || bus_error_in);
	assign dataAbtTake = instrEnd && (dataAbtPending || abortNow);
	assign fiqTake = instrEnd && !fiqSync && !current_status_word[cee_pkg::FMASK_BIT];
	assign irqTake = instrEnd && !irqSync && !current_status_word[cee_pkg::IMASK_BIT];
	assign fetchAbtTake = instrEnd && headAbortTag;
	assign undefTake = instrEnd && decodeUndef;
	assign trapTake = instrEnd && decodeTrap && !decodeUndef;
	assign curBank = bankOf(current_status_word[cee_pkg::MODE_MSB:0]);
	assign privileged = current_status_word[cee_pkg::MODE_MSB:0] != cee_pkg::MODE_USER;
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pready && pwrite;
	assign retFire = apbWrite && paddr == cee_pkg::RETURN_OFS && curBank != cee_pkg::NO_BANK && !entryFire;

	// Priority selection; the chain state forces the fast entry after a data abort.
	always_comb begin
		entryCause = cee_pkg::CAUSE_NONE;
		entryPc = instrPc;
		if (seq == cee_pkg::SEQ_CHAIN) begin
			entryCause = cee_pkg::CAUSE_FIQ;
			entryPc = pcTarget;
		end else if (dataAbtTake) begin
			entryCause = cee_pkg::CAUSE_DATA_ABT;
		end else if (fiqTake) begin
			entryCause = cee_pkg::CAUSE_FIQ;
		end else if (irqTake) begin
			entryCause = cee_pkg::CAUSE_IRQ;
		end else if (fetchAbtTake) begin
			entryCause = cee_pkg::CAUSE_FETCH_ABT;
		end else if (undefTake) begin
			entryCause = cee_pkg::CAUSE_UNDEF;
		end else if (trapTake) begin
			entryCause = cee_pkg::CAUSE_TRAP;
		end
	end

	assign entryFire = entryCause != cee_pkg::CAUSE_NONE;
	assign entryMode = modeOf(entryCause);
	assign entryBank = bankOf(entryMode);
	assign entryLink = entryPc + linkOfs(entryCause, current_status_word[cee_pkg::TSTATE_BIT]);
	assign entryVec = (hiVec ? cee_pkg::VEC_BASE_HIGH : cee_pkg::VEC_BASE_LOW) | vecOf(entryCause);

	// Sequencer: a data abort meeting an unmasked fast request chains into it.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			seq <= cee_pkg::SEQ_RUN;
		end else begin
			case (seq)
				cee_pkg::SEQ_RUN: begin
					if (entryCause == cee_pkg::CAUSE_DATA_ABT && fiqTake) begin
						seq <= cee_pkg::SEQ_CHAIN;
					end
				end
				cee_pkg::SEQ_CHAIN: seq <= cee_pkg::SEQ_RUN;
				default: seq <= cee_pkg::SEQ_RUN;
			endcase
		end
	end

	// Current status word: entry, return and privileged software writes.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			current_status_word <= cee_pkg::STATUS_RESET;
		end else if (entryFire) begin
			current_status_word[cee_pkg::MODE_MSB:0] <= entryMode;
			current_status_word[cee_pkg::TSTATE_BIT] <= 1'b0;
			current_status_word[cee_pkg::IMASK_BIT] <= 1'b1;
			if (entryCause == cee_pkg::CAUSE_FIQ || entryCause == cee_pkg::CAUSE_RESET) begin
				current_status_word[cee_pkg::FMASK_BIT] <= 1'b1;
			end
		end else if (retFire) begin
			current_status_word <= saved_status_word[curBank];
		end else if (apbWrite && paddr == cee_pkg::STATUS_OFS && privileged) begin
			current_status_word[cee_pkg::IMASK_BIT] <= pwdata[cee_pkg::IMASK_BIT];
			current_status_word[cee_pkg::FMASK_BIT] <= pwdata[cee_pkg::FMASK_BIT];
			if (modeLegal(pwdata[cee_pkg::MODE_MSB:0])) begin
				current_status_word[cee_pkg::MODE_MSB:0] <= pwdata[cee_pkg::MODE_MSB:0];
			end
		end
	end

	// Saved status words and banked link registers of the exception modes.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < BANK_COUNT; i++) begin
				saved_status_word[i] <= cee_pkg::STATUS_RESET;
				banked_link_reg[i] <= '0;
			end
		end else if (entryFire) begin
			saved_status_word[entryBank] <= current_status_word;
			banked_link_reg[entryBank] <= entryLink;
		end else if (apbWrite && paddr == cee_pkg::SAVED_OFS && curBank != cee_pkg::NO_BANK) begin
			saved_status_word[curBank] <= pwdata[7:0];
		end
	end

	// Fetch redirection: vector on entry, link value written on return.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pcLoad <= 1'b0;
			pcTarget <= '0;
			lastCause <= cee_pkg::CAUSE_NONE;
		end else begin
			pcLoad <= entryFire || retFire;
			if (entryFire) begin
				pcTarget <= entryVec;
				lastCause <= entryCause;
			end else if (retFire) begin
				pcTarget <= pwdata;
			end
		end
	end

	// Prefetch abort tag travels with the fetched instruction to the head.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			headAbortTag <= 1'b0;
		end else if (pipeFlush) begin
			headAbortTag <= 1'b0;
		end else if (fetchValid) begin
			headAbortTag <= protFault || bus_error_in;
		end else if (instrEnd) begin
			headAbortTag <= 1'b0;
		end
	end

	// Data abort bookkeeping within the current instruction.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dataAbtPending <= 1'b0;
			abortInInstr <= 1'b0;
		end else if (instrEnd) begin
			dataAbtPending <= 1'b0;
			abortInInstr <= 1'b0;
		end else if (abortNow) begin
			dataAbtPending <= 1'b1;
			abortInInstr <= 1'b1;
		end
	end

	// Register load and base write-back commits under an abort.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			regLoadCommit <= 1'b0;
			baseWbCommit <= 1'b0;
		end else begin
			case (xferKind)
				cee_pkg::XFER_SWAP: begin
					regLoadCommit <= loadReq && !(abortInInstr || abortNow);
					baseWbCommit <= wbReq && !(abortInInstr || abortNow);
				end
				cee_pkg::XFER_BLOCK: begin
					regLoadCommit <= loadReq && !(abortInInstr || abortNow);
					baseWbCommit <= wbReq;
				end
				default: begin
					regLoadCommit <= loadReq && !abortNow;
					baseWbCommit <= wbReq;
				end
			endcase
		end
	end

	// Control register: high vector select.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hiVec <= 1'b0;
		end else if (apbWrite && paddr == cee_pkg::CTRL_OFS) begin
			hiVec <= pwdata[cee_pkg::CTRL_HIVEC_BIT];
		end
	end

	// APB slave: data prepared in setup, answered in the first access cycle.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= apbSetup;
			pslverr <= 1'b0;
			prdata <= '0;
			if (apbSetup) begin
				case (paddr)
					cee_pkg::CTRL_OFS: prdata[cee_pkg::CTRL_HIVEC_BIT] <= hiVec;
					cee_pkg::STATUS_OFS: prdata[7:0] <= current_status_word;
					cee_pkg::SAVED_OFS: prdata[7:0] <= (curBank == cee_pkg::NO_BANK) ? 8'h00 : saved_status_word[curBank];
					cee_pkg::LINK_OFS: prdata <= (curBank == cee_pkg::NO_BANK) ? 32'h0 : banked_link_reg[curBank];
					cee_pkg::RETURN_OFS: prdata <= pcTarget;
					cee_pkg::CAUSE_OFS: prdata[2:0] <= lastCause;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	property p_sync_delay;
		@(posedge ref_clk) disable iff (!rstn)
		$past(rstn, 3) |-> fiqSync == $past(fast_irq_req_n, 2) && irqSync == $past(normal_irq_req_n, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("Request synchroniser delay wrong.");
	property p_data_abt_link;
		@(posedge ref_clk) disable iff (!rstn)
		(entryCause == cee_pkg::CAUSE_DATA_ABT) |=>
			banked_link_reg[cee_pkg::BANK_ABT] == $past(instrPc) + cee_pkg::LINK_PLUS8;
	endproperty
	a_data_abt_link: assert property (p_data_abt_link) else $error("Data abort link value wrong.");
	property p_compressed_link;
		@(posedge ref_clk) disable iff (!rstn)
		(entryCause inside {cee_pkg::CAUSE_TRAP, cee_pkg::CAUSE_UNDEF}) && current_status_word[cee_pkg::TSTATE_BIT] |=>
			banked_link_reg[$past(entryBank)] == $past(instrPc) + cee_pkg::LINK_PLUS2;
	endproperty
	a_compressed_link: assert property (p_compressed_link) else $error("Compressed trap link wrong.");
	property p_saved_copy;
		@(posedge ref_clk) disable iff (!rstn)
		entryFire |=> saved_status_word[$past(entryBank)] == $past(current_status_word);
	endproperty
	a_saved_copy: assert property (p_saved_copy) else $error("Saved status not copied on entry.");
	property p_mode_vector;
		@(posedge ref_clk) disable iff (!rstn)
		entryFire |=> pcLoad && pcTarget == $past(entryVec) && !current_status_word[cee_pkg::TSTATE_BIT] &&
			current_status_word[cee_pkg::MODE_MSB:0] == $past(entryMode) && current_status_word[cee_pkg::IMASK_BIT];
	endproperty
	a_mode_vector: assert property (p_mode_vector) else $error("Entry mode, vector or masks wrong.");
	property p_return;
		@(posedge ref_clk) disable iff (!rstn)
		retFire |=> current_status_word == $past(saved_status_word[curBank]) && pcLoad;
	endproperty
	a_return: assert property (p_return) else $error("Return did not restore the status word.");
	property p_fiq_masked;
		@(posedge ref_clk) disable iff (!rstn)
		current_status_word[cee_pkg::FMASK_BIT] && seq == cee_pkg::SEQ_RUN |-> entryCause != cee_pkg::CAUSE_FIQ;
	endproperty
	a_fiq_masked: assert property (p_fiq_masked) else $error("Masked fast interrupt was taken.");
	property p_user_write;
		@(posedge ref_clk) disable iff (!rstn)
		apbWrite && paddr == cee_pkg::STATUS_OFS && !privileged && !entryFire && !retFire |=>
			$stable(current_status_word);
	endproperty
	a_user_write: assert property (p_user_write) else $error("User mode changed the status word.");
	property p_priority;
		@(posedge ref_clk) disable iff (!rstn)
		seq == cee_pkg::SEQ_RUN && fiqTake && !dataAbtTake |-> entryCause == cee_pkg::CAUSE_FIQ;
	endproperty
	a_priority: assert property (p_priority) else $error("Fast interrupt lost priority.");
	property p_chain;
		@(posedge ref_clk) disable iff (!rstn)
		entryCause == cee_pkg::CAUSE_DATA_ABT && fiqTake |=>
			entryCause == cee_pkg::CAUSE_FIQ ##1 banked_link_reg[cee_pkg::BANK_FIQ] == $past(pcTarget) + cee_pkg::LINK_PLUS4;
	endproperty
	a_chain: assert property (p_chain) else $error("Fast entry did not follow data abort.");
	property p_swap_abort;
		@(posedge ref_clk) disable iff (!rstn)
		xferKind == cee_pkg::XFER_SWAP && abortNow |=> !regLoadCommit && !baseWbCommit;
	endproperty
	a_swap_abort: assert property (p_swap_abort) else $error("Aborted swap changed state.");
	property p_block_abort;
		@(posedge ref_clk) disable iff (!rstn)
		xferKind == cee_pkg::XFER_BLOCK && abortInInstr && !instrEnd |=> !regLoadCommit && baseWbCommit == $past(wbReq);
	endproperty
	a_block_abort: assert property (p_block_abort) else $error("Block abort commit wrong.");
endmodule
`default_nettype wire

// ---- testbench/cee_exception_unit_tb.sv ----
`default_nettype none
// Self-checking bench for the exception entry unit.
module cee_exception_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic wantFast = 1'b0, wantNormal = 1'b0, wantFault = 1'b0;
	logic fast_irq_req_n, normal_irq_req_n, bus_error_in;
	logic protFault = 1'b0, fetchValid = 1'b0, pipeFlush = 1'b0, dataAccess = 1'b0, instrEnd = 1'b0;
	logic decodeUndef = 1'b0, decodeTrap = 1'b0, loadReq = 1'b0, wbReq = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] instrPc = 32'h0, pwdata = 32'h0;
	logic [1:0] xferKind = 2'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] prdata, pcTarget, rdata;
	logic pready, pslverr, pcLoad, regLoadCommit, baseWbCommit, err;
	logic [7:0] status;
	int badCount = 0;
	int nCompared = 0;

	// Core clock, 25 ns period.
	always #12.5 ref_clk = ~ref_clk;

	cee_irq_abort_source srcU (.wantFast(wantFast), .wantNormal(wantNormal), .wantFault(wantFault),
		.dataAccess(dataAccess), .fast_irq_req_n(fast_irq_req_n), .normal_irq_req_n(normal_irq_req_n),
		.bus_error_in(bus_error_in));

	cee_exception_unit dut_u (.ref_clk(ref_clk), .rstn(rstn), .fast_irq_req_n(fast_irq_req_n),
		.normal_irq_req_n(normal_irq_req_n), .bus_error_in(bus_error_in), .protFault(protFault),
		.fetchValid(fetchValid), .pipeFlush(pipeFlush), .dataAccess(dataAccess), .instrEnd(instrEnd),
		.instrPc(instrPc), .decodeUndef(decodeUndef), .decodeTrap(decodeTrap), .xferKind(xferKind),
		.loadReq(loadReq), .wbReq(wbReq), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pcLoad(pcLoad),
		.pcTarget(pcTarget), .current_status_word(status), .regLoadCommit(regLoadCommit),
		.baseWbCommit(baseWbCommit));

	// Counts a comparison and reports a mismatch.
	task automatic cmpWord(input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is seen at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
	endtask

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		cmpWord(exp, rdata);
	endtask

	// Ends one instruction; kind is {data abort, software trap, undefined}.
	task automatic endInstr(input logic [31:0] pc, input logic [2:0] kind);
		@(posedge ref_clk);
		instrEnd <= 1'b1;
		instrPc <= pc;
		decodeUndef <= kind[0];
		decodeTrap <= kind[1];
		dataAccess <= kind[2];
		wantFault <= kind[2];
		@(posedge ref_clk);
		instrEnd <= 1'b0;
		decodeUndef <= 1'b0;
		decodeTrap <= 1'b0;
		dataAccess <= 1'b0;
		wantFault <= 1'b0;
		#1;
	endtask

	// Checks the fetch restart and the new status word.
	task automatic expEntry(input logic [31:0] target, input logic [7:0] st);
		cmpWord(32'h1, {31'h0, pcLoad});
		cmpWord(target, pcTarget);
		cmpWord({24'h0, st}, {24'h0, status});
	endtask

	// One data access cycle with register load and base write-back requests.
	task automatic xfer(input logic [1:0] k, input logic fault, input logic expLoad, input logic expWb);
		@(posedge ref_clk);
		xferKind <= k;
		dataAccess <= 1'b1;
		wantFault <= fault;
		loadReq <= 1'b1;
		wbReq <= 1'b1;
		@(posedge ref_clk);
		dataAccess <= 1'b0;
		wantFault <= 1'b0;
		loadReq <= 1'b0;
		wbReq <= 1'b0;
		#1;
		cmpWord({30'h0, expLoad, expWb}, {30'h0, regLoadCommit, baseWbCommit});
	endtask

	// A faulting fetch, optionally flushed by a branch.
	task automatic fetchFault(input logic flush);
		@(posedge ref_clk);
		fetchValid <= 1'b1;
		protFault <= 1'b1;
		@(posedge ref_clk);
		fetchValid <= 1'b0;
		protFault <= 1'b0;
		pipeFlush <= flush;
		@(posedge ref_clk);
		pipeFlush <= 1'b0;
	endtask

	task automatic summarize();
		$display("Compared %0d, mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Cuts a hang short well after the sequence should have ended.
	initial begin
		repeat (6000) @(posedge ref_clk);
		badCount++;
		summarize();
	end

	// Main sequence.
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		#1;
		cmpWord(32'hd3, {24'h0, status});
		apb(1'b0, 8'h40, 32'h0);
		cmpWord(32'h1, {31'h0, err});
		wr(cee_pkg::STATUS_OFS, 32'h10);
		wr(cee_pkg::STATUS_OFS, 32'hd0);
		cmpWord(32'h10, {24'h0, status});
		rd(cee_pkg::STATUS_OFS, 32'h10);
		$display("test registers done");
		endInstr(32'h100, 3'b010);
		expEntry(32'h8, 8'h93);
		rd(cee_pkg::SAVED_OFS, 32'h10);
		rd(cee_pkg::LINK_OFS, 32'h104);
		wr(cee_pkg::SAVED_OFS, 32'h30);
		wr(cee_pkg::RETURN_OFS, 32'h200);
		expEntry(32'h200, 8'h30);
		rd(cee_pkg::RETURN_OFS, 32'h200);
		endInstr(32'h200, 3'b001);
		expEntry(32'h4, 8'h9b);
		rd(cee_pkg::LINK_OFS, 32'h202);
		$display("test traps done");
		wr(cee_pkg::STATUS_OFS, 32'h1f);
		wr(cee_pkg::CTRL_OFS, 32'h1);
		rd(cee_pkg::CTRL_OFS, 32'h1);
		@(posedge ref_clk);
		wantNormal <= 1'b1;
		endInstr(32'h2fc, 3'b000);
		cmpWord(32'h0, {31'h0, pcLoad});
		endInstr(32'h300, 3'b000);
		expEntry(32'hffff0018, 8'h92);
		rd(cee_pkg::LINK_OFS, 32'h304);
		endInstr(32'h304, 3'b000);
		cmpWord(32'h0, {31'h0, pcLoad});
		wr(cee_pkg::CTRL_OFS, 32'h0);
		wr(cee_pkg::STATUS_OFS, 32'h1f);
		@(posedge ref_clk);
		wantFast <= 1'b1;
		repeat (3) @(posedge ref_clk);
		endInstr(32'h400, 3'b001);
		expEntry(32'h1c, 8'hd1);
		endInstr(32'h404, 3'b000);
		cmpWord(32'h0, {31'h0, pcLoad});
		@(posedge ref_clk);
		wantNormal <= 1'b0;
		$display("test interrupts done");
		wr(cee_pkg::STATUS_OFS, 32'h1f);
		endInstr(32'h500, 3'b100);
		expEntry(32'h10, 8'h97);
		@(posedge ref_clk);
		#1;
		expEntry(32'h1c, 8'hd1);
		rd(cee_pkg::LINK_OFS, 32'h14);
		rd(cee_pkg::CAUSE_OFS, 32'h7);
		@(posedge ref_clk);
		wantFast <= 1'b0;
		$display("test abort chain done");
		for (int k = 0; k < 3; k++) begin
			xfer(2'(k), 1'b0, 1'b1, 1'b1);
			xfer(2'(k), 1'b1, 1'b0, k != 1);
			xfer(2'(k), 1'b0, k == 0, k != 1);
			endInstr(32'h600, 3'b000);
			expEntry(32'h10, 8'hd7);
		end
		$display("test transfers done");
		fetchFault(1'b1);
		endInstr(32'h700, 3'b000);
		cmpWord(32'h0, {31'h0, pcLoad});
		fetchFault(1'b0);
		endInstr(32'h704, 3'b000);
		expEntry(32'hc, 8'hd7);
		rd(cee_pkg::LINK_OFS, 32'h708);
		$display("test prefetch done");
		summarize();
	end
endmodule
`default_nettype wire

// ---- testbench/cee_irq_abort_source.sv ----
`default_nettype none
// Behavioural model of the interrupt sources and the memory bus error signalling.
module cee_irq_abort_source (
	input wire logic wantFast,
	input wire logic wantNormal,
	input wire logic wantFault,
	input wire logic dataAccess,
	output logic fast_irq_req_n,
	output logic normal_irq_req_n,
	output logic bus_error_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// Request pins follow the wanted levels; the unit synchronises them itself.
	assign fast_irq_req_n = ~wantFast;
	assign normal_irq_req_n = ~wantNormal;
	// The bus error is only signalled inside a data access cycle.
	assign bus_error_in = wantFault & dataAccess;
endmodule
`default_nettype wire
